/* File: shared/ebw_pkg.sv */
package ebw_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int          NWIN           = 5;
  localparam logic [15:0] OFS_WIN_CFG0   = 16'hF0C0;
  localparam logic [15:0] OFS_WIN_SEL1   = 16'hF0E0;
  localparam logic [15:0] OFS_SNAPSHOT   = 16'hF108;
  localparam logic [15:0] OFS_STEP       = 16'h0004;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] WIN_CFG_WMASK  = 16'hF6FF;
  localparam logic [7:0]  SNAP_RST       = 8'hFF;
  localparam logic [2:0]  CLK_RATIO_RST  = 3'h7;
  localparam logic [5:0]  RATIO_X2_RST   = 6'h08;
  localparam logic [3:0]  WAIT_MAX       = 4'hF;
  localparam logic [3:0]  SEL_SIZE_MAX   = 4'hC;
  localparam logic [2:0]  SYNC_FILL      = 3'h5;
  localparam int          SNAP_P0_LSB    = 8;
  localparam int          KIND_P0_LSB    = 6;
  localparam int          RATIO_P0_LSB   = 13;
  localparam int          PIN_EA         = 16;
  localparam int          PIN_LONG_RESET = 17;

  // ----------------------------------------------------------------
  // Bus kinds
  // ----------------------------------------------------------------
  localparam logic [1:0] KIND_8_DEMUX  = 2'h0;
  localparam logic [1:0] KIND_8_MUX    = 2'h1;
  localparam logic [1:0] KIND_16_DEMUX = 2'h2;
  localparam logic [1:0] KIND_16_MUX   = 2'h3;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr_sel_en;
    logic       rd_sel_en;
    logic       rdy_pol;
    logic       ready_input_enable;
    logic       rsv_11;
    logic       bus_window_enable;
    logic       latch_strobe_stretch;
    logic       rsv_8;
    logic [1:0] bus_kind;
    logic       tristate_wait_ctl;
    logic       strobe_delay_ctl;
    logic [3:0] cycle_wait_field;
  } ebw_win_cfg_s;

  typedef struct packed {
    logic       ale;
    logic       rd_n;
    logic       wr_n;
    logic       bhe_n;
    logic [4:0] cs_n;
  } ebw_ext_bus_s;

  localparam ebw_ext_bus_s BUS_IDLE = '{1'b0, 1'b1, 1'b1, 1'b1, 5'h1F};

endpackage : ebw_pkg

/* File: logic/ebw_cycle_timer.sv */
`timescale 1ns/10ps
module ebw_cycle_timer
(
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic                  ce,
  input  wire logic                  start,
  input  wire ebw_pkg::ebw_win_cfg_s cfg,
  input  wire logic                  wr,
  input  wire logic [1:0]            be,
  input  wire logic [4:0]            cs_bit,
  input  wire logic                  wmode,
  input  wire logic                  ready_pin,
  output ebw_pkg::ebw_ext_bus_s      bus,
  output logic                       done
);
  import ebw_pkg::*;

  typedef enum logic [2:0] {PH_IDLE, PH_ALE, PH_DELAY, PH_STROBE, PH_TRI} ebw_phase_e;

  typedef struct packed {
    ebw_phase_e   ph;
    logic [3:0]   cnt;
    logic [2:0]   rdy_s;
    logic         rdy_f;
    ebw_win_cfg_s cfg;
    logic         wr;
    logic [1:0]   be;
    logic [4:0]   cs_bit;
    logic         wmode;
    ebw_ext_bus_s bus;
    logic         done;
  } ebw_tmr_s;

  ebw_tmr_s q;
  ebw_tmr_s d;
  logic     end_strobe;

  // ----------------------------------------------------------------
  // Strobe drive
  // ----------------------------------------------------------------
  function automatic ebw_ext_bus_s drive(input ebw_tmr_s s, input logic on);
    logic cs_on;
    cs_on = on | ~(s.wr ? s.cfg.wr_sel_en : s.cfg.rd_sel_en);
    drive = s.bus;
    drive.rd_n = ~(on & ~s.wr);
    drive.wr_n = ~(on & s.wr & (s.wmode | s.be[0]));
    drive.bhe_n = s.wmode ? ~s.be[1] : ~(on & s.wr & s.be[1]);
    drive.cs_n = ~(s.cs_bit & {5{cs_on}});
  endfunction : drive

  // ----------------------------------------------------------------
  // Cycle sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    d = q;
    d.done = 1'b0;
    d.rdy_s = {q.rdy_s[1:0], ready_pin};
    if (q.rdy_s[1] == q.rdy_s[2])
    begin
      d.rdy_f = q.rdy_s[2];
    end
    end_strobe = q.cfg.ready_input_enable ? (q.rdy_f == q.cfg.rdy_pol)
                                          : (q.cnt == 4'h0);
    case (q.ph)
      PH_IDLE:
      begin
        if (start)
        begin
          d.cfg = cfg;
          d.wr = wr;
          d.be = be;
          d.cs_bit = cs_bit;
          d.wmode = wmode;
          d.ph = PH_ALE;
          d.cnt = {3'h0, cfg.latch_strobe_stretch};
          d.bus = drive(d, 1'b0);
          d.bus.ale = 1'b1;
        end
      end
      PH_ALE:
      begin
        if (q.cnt != 4'h0)
        begin
          d.cnt = q.cnt - 4'h1;
        end
        else
        begin
          d.bus.ale = 1'b0;
          d.cnt = WAIT_MAX - q.cfg.cycle_wait_field;
          if (q.cfg.strobe_delay_ctl)
          begin
            d.ph = PH_STROBE;
            d.bus = drive(q, 1'b1);
            d.bus.ale = 1'b0;
          end
          else
          begin
            d.ph = PH_DELAY;
          end
        end
      end
      PH_DELAY:
      begin
        d.ph = PH_STROBE;
        d.bus = drive(q, 1'b1);
      end
      PH_STROBE:
      begin
        if (end_strobe)
        begin
          d.bus = drive(q, 1'b0);
          if (!q.cfg.tristate_wait_ctl)
          begin
            d.ph = PH_TRI;
          end
          else
          begin
            d.ph = PH_IDLE;
            d.done = 1'b1;
            d.bus = BUS_IDLE;
          end
        end
        else if (!q.cfg.ready_input_enable)
        begin
          d.cnt = q.cnt - 4'h1;
        end
      end
      PH_TRI:
      begin
        d.ph = PH_IDLE;
        d.done = 1'b1;
        d.bus = BUS_IDLE;
      end
      default:
      begin
        d.ph = PH_IDLE;
        d.bus = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      q <= '0;
      q.bus <= BUS_IDLE;
    end
    else if (ce)
    begin
      q <= d;
    end
  end

  assign bus = q.bus;
  assign done = q.done;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk iff ce); endclocking
  default disable iff (!resetn);

  chk_ale_stretch: assert property (
    (q.ph == PH_IDLE && start && cfg.latch_strobe_stretch)
      |=> bus.ale [*2] ##1 !bus.ale)
    else $error("stretched latch strobe not two cycles");

  chk_strobe_delay: assert property (
    (q.ph == PH_IDLE && start && !cfg.latch_strobe_stretch && !cfg.strobe_delay_ctl)
      |=> ##1 (q.ph == PH_DELAY && !bus.ale) ##1 q.ph == PH_STROBE)
    else $error("strobe delay phase missing");

  chk_wait_count: assert property (
    (q.ph == PH_IDLE && start && !cfg.latch_strobe_stretch && cfg.strobe_delay_ctl
     && !cfg.ready_input_enable && cfg.cycle_wait_field == 4'hD)
      |=> ##1 (q.ph == PH_STROBE) [*3] ##1 q.ph != PH_STROBE)
    else $error("wait state count wrong");

  chk_tristate_wait: assert property (
    (q.ph == PH_STROBE && end_strobe && !q.cfg.tristate_wait_ctl)
      |=> !done ##1 done)
    else $error("tristate wait cycle wrong");

  chk_ready_hold: assert property (
    (q.ph == PH_STROBE && q.cfg.ready_input_enable && q.rdy_f != q.cfg.rdy_pol)
      |=> q.ph == PH_STROBE)
    else $error("cycle ended without ready");

endmodule : ebw_cycle_timer

/* File: logic/ebw_bus_window_ctl.sv */
// Chosen here: the APB slave port.
`timescale 1ns/10ps
module ebw_bus_window_ctl
(
  input  wire logic                clk,
  input  wire logic                resetn,
  input  wire logic                por_resetn,
  input  wire logic                ce,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [15:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic [15:0]         port0_pins,
  input  wire logic                external_access_pin,
  input  wire logic                long_reset_pin,
  input  wire logic                ready_pin,
  input  wire logic                acc_req,
  input  wire logic [23:0]         acc_addr,
  input  wire logic                acc_wr,
  input  wire logic [1:0]          acc_be,
  output logic                     acc_ack,
  output logic                     acc_refused,
  output logic                     acc_width16,
  output logic                     acc_muxed,
  output logic [7:0]               seg_line_en,
  output logic [5:0]               cpu_ratio_x2,
  output ebw_pkg::ebw_ext_bus_s    ext_bus
);
  import ebw_pkg::*;

  typedef struct packed {
    logic [17:0]                  pin_s1;
    logic [17:0]                  pin_s2;
    logic [17:0]                  pin_s3;
    logic [17:0]                  pin_f;
    logic [2:0]                   cap_cnt;
    ebw_win_cfg_s [NWIN-1:0]      cfg;
    logic [NWIN-2:0][15:0]        sel;
    logic [4:0]                   snap_lo;
    logic [31:0]                  prdata;
    logic                         pready;
    logic                         pslverr;
    logic                         busy;
    logic                         acc_ack;
    logic                         acc_refused;
    logic                         width16;
    logic                         muxed;
    logic [7:0]                   seg_en;
    logic [4:0]                   cs_allow;
  } ebw_top_s;

  typedef struct packed {
    logic [2:0] ratio;
    logic [5:0] x2;
  } ebw_clk_s;

  ebw_top_s     q;
  ebw_top_s     d;
  ebw_clk_s     cq;
  ebw_clk_s     cd;
  logic         cap;
  logic         take;
  logic         start;
  logic         tmr_done;
  logic [2:0]   idx;
  logic         apb_setup;
  logic         apb_write;
  ebw_win_cfg_s zero_cfg;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] cfg_ofs(input int i);
    cfg_ofs = OFS_WIN_CFG0 + 16'(i * 4);
  endfunction : cfg_ofs

  function automatic logic [15:0] sel_ofs(input int i);
    sel_ofs = OFS_WIN_SEL1 + 16'(i * 4);
  endfunction : sel_ofs

  // Lowest numbered enabled window wins; window zero catches the rest
  function automatic logic [2:0] pick_win(input logic [23:0] a,
                                          input logic [NWIN-2:0][15:0] s,
                                          input ebw_win_cfg_s [NWIN-1:0] c);
    logic [11:0] m;
    pick_win = 3'h0;
    for (int i = NWIN - 2; i >= 0; i--)
    begin
      m = (s[i][3:0] >= SEL_SIZE_MAX) ? 12'h000 : 12'(12'hFFF << s[i][3:0]);
      if (c[i+1].bus_window_enable && ((a[23:12] & m) == (s[i][15:4] & m)))
      begin
        pick_win = 3'(i + 1);
      end
    end
  endfunction : pick_win

  function automatic logic [4:0] cs_mask(input logic [1:0] code);
    case (code)
      2'h0:    cs_mask = 5'h07;
      2'h1:    cs_mask = 5'h03;
      2'h2:    cs_mask = 5'h00;
      default: cs_mask = 5'h1F;
    endcase
  endfunction : cs_mask

  function automatic logic [7:0] seg_mask(input logic [1:0] code);
    case (code)
      2'h0:    seg_mask = 8'h0F;
      2'h1:    seg_mask = 8'h00;
      2'h2:    seg_mask = 8'hFF;
      default: seg_mask = 8'h03;
    endcase
  endfunction : seg_mask

  // Twice the multiplier, so that the half ratio stays an integer
  function automatic logic [5:0] ratio_x2(input logic [2:0] code);
    case (code)
      3'h0:    ratio_x2 = 6'h20;
      3'h1:    ratio_x2 = 6'h01;
      3'h2:    ratio_x2 = 6'h14;
      3'h3:    ratio_x2 = 6'h02;
      3'h4:    ratio_x2 = 6'h0A;
      3'h5:    ratio_x2 = 6'h10;
      3'h6:    ratio_x2 = 6'h06;
      default: ratio_x2 = 6'h08;
    endcase
  endfunction : ratio_x2

  // ----------------------------------------------------------------
  // Main next state
  // ----------------------------------------------------------------
  always_comb
  begin
    d = q;
    d.acc_ack = 1'b0;
    d.acc_refused = 1'b0;

    // Pin synchroniser; a level counts once stages two and three agree
    d.pin_s1 = {long_reset_pin, external_access_pin, port0_pins};
    d.pin_s2 = q.pin_s1;
    d.pin_s3 = q.pin_s2;
    d.pin_f = ((q.pin_s2 ~^ q.pin_s3) & q.pin_s3) | ((q.pin_s2 ^ q.pin_s3) & q.pin_f);

    // Reset configuration capture, once the filter has settled
    cap = (q.cap_cnt == 3'h1);
    if (q.cap_cnt != 3'h0)
    begin
      d.cap_cnt = q.cap_cnt - 3'h1;
    end

    // APB slave: data is registered in setup, pready rises for access
    apb_setup = psel & ~penable;
    apb_write = psel & penable & q.pready & pwrite & ~q.pslverr;
    d.pready = apb_setup & ~q.pready;
    if (apb_setup)
    begin
      d.pslverr = 1'b1;
      d.prdata = 32'h0000_0000;
      for (int i = 0; i < NWIN; i++)
      begin
        if (paddr == cfg_ofs(i))
        begin
          d.pslverr = 1'b0;
          d.prdata = {16'h0000, q.cfg[i]};
        end
      end
      for (int i = 0; i < NWIN - 1; i++)
      begin
        if (paddr == sel_ofs(i))
        begin
          d.pslverr = 1'b0;
          d.prdata = {16'h0000, q.sel[i]};
        end
      end
      if (paddr == OFS_SNAPSHOT)
      begin
        d.pslverr = 1'b0;
        d.prdata = {24'h00_0000, cq.ratio, q.snap_lo};
      end
    end

    // Snapshot has no write path at all
    if (apb_write)
    begin
      for (int i = 0; i < NWIN; i++)
      begin
        if (paddr == cfg_ofs(i))
        begin
          d.cfg[i] = ebw_win_cfg_s'(pwdata[15:0] & WIN_CFG_WMASK);
        end
      end
      for (int i = 0; i < NWIN - 1; i++)
      begin
        if (paddr == sel_ofs(i))
        begin
          d.sel[i] = pwdata[15:0];
        end
      end
    end

    // Capture overrides a software write in the same cycle
    zero_cfg = '0;
    zero_cfg.bus_window_enable = 1'b1;
    zero_cfg.latch_strobe_stretch = 1'b1;
    zero_cfg.bus_kind = q.pin_f[KIND_P0_LSB +: 2];
    if (cap)
    begin
      d.snap_lo = q.pin_f[SNAP_P0_LSB +: 5];
      d.cfg[0] = q.pin_f[PIN_EA] ? '0 : zero_cfg;
    end
    d.cs_allow = cs_mask(d.snap_lo[2:1]);
    d.seg_en = seg_mask(d.snap_lo[4:3]);

    // Access path: no request is taken until capture is done
    idx = pick_win(acc_addr, q.sel, q.cfg);
    take = acc_req & ~q.busy & ~q.acc_ack & ~q.acc_refused & (q.cap_cnt == 3'h0);
    start = take & q.cfg[idx].bus_window_enable;
    if (take)
    begin
      if (start)
      begin
        d.busy = 1'b1;
        d.width16 = q.cfg[idx].bus_kind[1];
        d.muxed = q.cfg[idx].bus_kind[0];
      end
      else
      begin
        d.acc_refused = 1'b1;
      end
    end
    if (tmr_done)
    begin
      d.busy = 1'b0;
      d.acc_ack = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      q <= '0;
      q.cap_cnt <= SYNC_FILL;
      q.snap_lo <= SNAP_RST[4:0];
    end
    else if (ce)
    begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Clock ratio, kept through every reset but power-on and a long reset
  // ----------------------------------------------------------------
  always_comb
  begin
    cd = cq;
    if (cap && q.pin_f[PIN_LONG_RESET])
    begin
      cd.ratio = q.pin_f[RATIO_P0_LSB +: 3];
    end
    cd.x2 = ratio_x2(cd.ratio);
  end

  always_ff @(posedge clk or negedge por_resetn)
  begin
    if (!por_resetn)
    begin
      cq.ratio <= CLK_RATIO_RST;
      cq.x2 <= RATIO_X2_RST;
    end
    else if (ce)
    begin
      cq <= cd;
    end
  end

  // ----------------------------------------------------------------
  // Bus cycle timing
  // ----------------------------------------------------------------
  ebw_cycle_timer u_timer
  (
    .clk       (clk),
    .resetn    (resetn),
    .ce        (ce),
    .start     (start),
    .cfg       (q.cfg[idx]),
    .wr        (acc_wr),
    .be        (acc_be),
    .cs_bit    (5'(5'h01 << idx) & q.cs_allow),
    .wmode     (q.snap_lo[0]),
    .ready_pin (ready_pin),
    .bus       (ext_bus),
    .done      (tmr_done)
  );

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign acc_ack = q.acc_ack;
  assign acc_refused = q.acc_refused;
  assign acc_width16 = q.width16;
  assign acc_muxed = q.muxed;
  assign seg_line_en = q.seg_en;
  assign cpu_ratio_x2 = cq.x2;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk iff ce); endclocking
  default disable iff (!resetn);

  chk_refuse_disabled: assert property (
    (take && !q.cfg[idx].bus_window_enable) |=> (acc_refused && !q.busy))
    else $error("disabled window not refused");

  chk_zero_ea_high: assert property (
    (cap && q.pin_f[PIN_EA]) |=> q.cfg[0] == '0)
    else $error("window zero not cleared");

  chk_zero_ea_low: assert property (
    (cap && !q.pin_f[PIN_EA]) |=> (q.cfg[0].bus_window_enable
      && q.cfg[0].latch_strobe_stretch
      && q.cfg[0].bus_kind == $past(q.pin_f[KIND_P0_LSB +: 2])))
    else $error("window zero reset setup wrong");

  chk_snap_capture: assert property (
    cap |=> q.snap_lo == $past(q.pin_f[SNAP_P0_LSB +: 5]))
    else $error("snapshot not loaded from pins");

  chk_snap_readonly: assert property (
    (!cap && apb_write && paddr == OFS_SNAPSHOT) |=> $stable(q.snap_lo))
    else $error("snapshot changed by write");

  chk_ratio_hold: assert property (
    !(cap && q.pin_f[PIN_LONG_RESET]) |=> $stable(cq.ratio))
    else $error("clock ratio changed without long reset");

  chk_cs_lines: assert property (
    ((ext_bus.cs_n | q.cs_allow) == 5'h1F) && $countones(~ext_bus.cs_n) <= 1)
    else $error("disabled select line driven");

  cov_refused: cover property (take && !start);
  cov_done_cycle: cover property (start ##[1:40] tmr_done);
  cov_apb_read: cover property (psel && penable && pready && !pwrite && !pslverr);

endmodule : ebw_bus_window_ctl

/* File: verification/ebw_ext_mem.sv */
`timescale 1ns/10ps
module ebw_ext_mem
(
  input  wire logic                 clk,
  input  wire logic                 resetn,
  input  wire ebw_pkg::ebw_ext_bus_s bus,
  input  wire logic [7:0]           ready_dly,
  output logic                      ready_pin
);
  import ebw_pkg::*;
  // --------------------------------
  // Slow memory answering with ready
  // --------------------------------
  logic [7:0] cnt_q;
  logic       strobe;
  assign strobe = !(bus.rd_n && bus.wr_n);
  // Count only within a strobe, so a stale count never ends a later cycle early
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      cnt_q <= 8'h00;
    else if (!strobe)
      cnt_q <= 8'h00;
    else if (cnt_q != 8'hFF)
      cnt_q <= cnt_q + 8'h01;
  end
  // Low is the idle level, so no cycle ends without a real answer
  assign ready_pin = strobe && (cnt_q >= ready_dly);
endmodule : ebw_ext_mem

/* File: verification/external_bus_window_config_tb.sv */
`timescale 1ns/10ps
module external_bus_window_config_tb;
  import ebw_pkg::*;
  logic         clk, resetn, por_resetn, psel, penable, pwrite, ea, lng, acc_req, ce;
  logic         pready, pslverr, acc_ack, acc_refused, acc_width16, acc_muxed, rdy, err, rf;
  logic [15:0]  paddr, pins, c;
  logic [31:0]  pwdata, prdata, rd;
  logic [7:0]   seg_line_en, dly;
  logic [5:0]   cpu_ratio_x2;
  logic [23:0]  addr;
  ebw_ext_bus_s ext_bus;
  int           fails, n_checks, n;
  int           rt[8] = '{32, 1, 20, 2, 10, 16, 6, 8};
  logic [7:0]   sm[4] = '{8'h0F, 8'h00, 8'hFF, 8'h03};
  logic [15:0]  tc[4] = '{16'h043D, 16'h064E, 16'h04A0, 16'h07C5};

  ebw_bus_window_ctl uut (.clk(clk), .resetn(resetn), .por_resetn(por_resetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .port0_pins(pins),
    .external_access_pin(ea), .long_reset_pin(lng), .ready_pin(rdy), .acc_req(acc_req),
    .acc_addr(addr), .acc_wr(1'b0), .acc_be(2'h3), .acc_ack(acc_ack),
    .acc_refused(acc_refused), .acc_width16(acc_width16), .acc_muxed(acc_muxed),
    .seg_line_en(seg_line_en), .cpu_ratio_x2(cpu_ratio_x2), .ext_bus(ext_bus));
  ebw_ext_mem mem (.clk(clk), .resetn(resetn), .bus(ext_bus), .ready_dly(dly),
    .ready_pin(rdy));

  // --------------------------------
  // Shared tasks
  // --------------------------------
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      fails++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task final_report;
    if (fails == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report

  task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    // A slave that never answers counts against the run
    if (pready !== 1'b1)
      fails++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rst(input logic e, input logic l, input logic [15:0] p);
    @(posedge clk);
    resetn <= 1'b0; ea <= e; lng <= l; pins <= p;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : rst

  // Counts edges from the take edge to the edge that sees the answer
  task access;
    @(posedge clk);
    acc_req <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (acc_ack !== 1'b1 && acc_refused !== 1'b1 && n < 80);
    rf = acc_refused;
    if (acc_ack !== 1'b1 && acc_refused !== 1'b1)
      fails++;
    acc_req <= 1'b0;
  endtask : access

  // --------------------------------
  // Scenarios
  // --------------------------------
  task t_defaults;
    apb(0, OFS_SNAPSHOT, 0); chk(rd, 32'hFF);
    chk(cpu_ratio_x2, 8);
    apb(0, OFS_WIN_CFG0, 0); chk(rd, 32'h06C0);
    apb(1, OFS_SNAPSHOT, 0); apb(0, OFS_SNAPSHOT, 0); chk(rd, 32'hFF);
    apb(0, 16'hF100, 0); chk({err, rd[30:0]}, 32'h80000000);
  endtask : t_defaults

  task t_pins;
    for (int i = 0; i < 8; i++)
    begin
      rst(0, 1, {i[2:0], i[1:0], 3'h7, i[1:0], 6'h3F});
      apb(0, OFS_SNAPSHOT, 0); chk(rd, {i[2:0], i[1:0], 3'h7});
      chk(cpu_ratio_x2, rt[i]);
      chk(seg_line_en, sm[i[1:0]]);
      apb(0, OFS_WIN_CFG0, 0); chk(rd, 32'h0600 | (i[1:0] << 6));
    end
    rst(0, 0, 16'h1FFF);
    chk(cpu_ratio_x2, 8);
  endtask : t_pins

  task t_ea_high;
    rst(1, 0, 16'hFFFF);
    apb(0, OFS_WIN_CFG0, 0); chk(rd, 0);
    access; chk(rf, 1);
    apb(1, OFS_WIN_CFG0, 32'h043F); access; chk({rf, n[7:0]}, 5);
  endtask : t_ea_high

  task t_timing;
    for (int i = 0; i < 4; i++)
    begin
      c = tc[i];
      apb(1, OFS_WIN_CFG0, c);
      access;
      chk(n, 5 + c[9] + (1 - c[4]) + (15 - c[3:0]) + (1 - c[5]));
      chk({acc_width16, acc_muxed}, c[7:6]);
    end
  endtask : t_timing

  // Three frozen edges in mid-cycle stretch the answer by three
  task t_freeze;
    apb(1, OFS_WIN_CFG0, 32'h043F);
    fork
      access;
      begin
        repeat (3) @(posedge clk);
        ce <= 1'b0;
        repeat (2) @(posedge clk);
        chk(ext_bus, 32'h05E);
        @(posedge clk);
        ce <= 1'b1;
      end
    join
    chk(n, 8);
  endtask : t_freeze

  task t_window;
    apb(1, OFS_WIN_SEL1, 32'h0010);
    apb(1, OFS_WIN_CFG0 + OFS_STEP, 32'h04BF);
    addr <= 24'h001000;
    access;
    chk({acc_width16, acc_muxed}, 2'h2);
    addr <= 24'h002000;
    access;
    chk({acc_width16, acc_muxed}, 2'h0);
  endtask : t_window

  task t_ready;
    dly <= 8'h19;
    apb(1, OFS_WIN_CFG0, 32'h3430);
    access; chk(n > 27 && n < 40 && !rf, 1);
  endtask : t_ready

  initial
  begin
    clk = 0;
    forever #10 clk = ~clk;
  end

  initial
  begin
    {resetn, por_resetn, psel, penable, pwrite, ea, acc_req} = '0;
    {paddr, pwdata, dly, fails, n_checks} = '0;
    lng = 1'b1;
    ce = 1'b1;
    addr = 24'h001000;
    pins = 16'hFFFF;
    repeat (6) @(posedge clk);
    resetn <= 1'b1; por_resetn <= 1'b1;
    repeat (8) @(posedge clk);
    t_defaults;
    t_pins;
    t_ea_high;
    t_timing;
    t_freeze;
    t_window;
    t_ready;
    final_report;
  end

  initial
  begin
    #1000000;
    fails++;
    final_report;
  end
endmodule : external_bus_window_config_tb
